// *** acr_pkg.sv ***
package acr_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int RES_W  = 12;
    localparam int CHAN_W = 5;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFF_CTRL1 = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_CTRL2 = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_RESH  = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_RESL  = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_CVH   = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_CVL   = 3'h5;
    localparam logic [ADDR_W-1:0] OFF_CFG   = 3'h6;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int FLAG_BIT   = 7;
    localparam int IRQEN_BIT  = 6;
    localparam int CONT_BIT   = 5;
    localparam int CHAN_LSB   = 0;
    localparam int ACTIVE_BIT = 7;
    localparam int TRIG_BIT   = 6;
    localparam int CMPEN_BIT  = 5;
    localparam int CMPGE_BIT  = 4;
    localparam int MODE_LSB   = 2;

    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [CHAN_W-1:0] CHAN_OFF   = 5'h1F;
    localparam logic [CHAN_W-1:0] CHAN_REFH  = 5'h1D;
    localparam logic [CHAN_W-1:0] CHAN_REFL  = 5'h1E;
    localparam logic [CHAN_W-1:0] CHAN_LASTP = 5'h1B;
    localparam logic [1:0]        MODE_8     = 2'h0;
    localparam logic [1:0]        MODE_12    = 2'h1;
    localparam logic [1:0]        MODE_10    = 2'h2;
    localparam logic [CHAN_W-1:0] CHAN_RST   = 5'h1F;
    localparam logic [1:0]        MODE_RST   = 2'h0;

    typedef enum logic {ACR_IDLE, ACR_BUSY} acr_state_t;

    // Reserved mode falls back to the 8-bit view
    function automatic logic [RES_W-1:0] acr_mask(
        input logic [RES_W-1:0] v,
        input logic [1:0]       m
    );
        case (m)
            MODE_12: return v;
            MODE_10: return {2'h0, v[9:0]};
            default: return {4'h0, v[7:0]};
        endcase
    endfunction : acr_mask

endpackage : acr_pkg

// *** acr_trig_sync.sv ***
`timescale 1ns/1ps
module acr_trig_sync (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic hwTriggerIn,
    output logic      trigEvent
);

    logic syncA_reg;
    logic syncB_reg;
    logic prev_reg;

    // ************************************************************
    // Two-stage synchroniser and rising-edge detect
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            syncA_reg <= 1'b0;
            syncB_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            syncA_reg <= hwTriggerIn;
            syncB_reg <= syncA_reg;
            prev_reg  <= syncB_reg;
        end
    end

    // Held-high trigger yields only one event
    assign trigEvent = syncB_reg & ~prev_reg;

endmodule : acr_trig_sync

// *** acr_top.sv ***
`timescale 1ns/1ps
module acr_top
    import acr_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic              wrStrobe,
    input  wire logic              rdStrobe,
    output logic      [DATA_W-1:0] rdData_reg,
    input  wire logic              hwTriggerIn,
    input  wire logic              convDoneIn,
    input  wire logic [RES_W-1:0]  convResultIn,
    output logic                   convStart_reg,
    output logic                   convAbort_reg,
    output logic                   busy_reg,
    output logic      [CHAN_W-1:0] convChannel_reg,
    output logic                   convPinSel_reg,
    output logic                   convRefHigh_reg,
    output logic                   convRefLow_reg,
    output logic                   irq_reg
);

    // ************************************************************
    // Declarations
    // ************************************************************
    acr_state_t        state_reg;
    acr_state_t        state_next;
    logic              irqEn_reg;
    logic              cont_reg;
    logic [CHAN_W-1:0] chan_reg;
    logic              trig_reg;
    logic              cmpEn_reg;
    logic              cmpGe_reg;
    logic [1:0]        mode_reg;
    logic [RES_W-1:0]  cmpVal_reg;
    logic              flag_reg;
    logic              lock_reg;
    logic [3:0]        resHigh_reg;
    logic [7:0]        resLow_reg;
    logic              wrCtrl1;
    logic              wrCtrl2;
    logic              rdHigh;
    logic              rdLow;
    logic              trigEvent;
    logic              busy;
    logic [RES_W-1:0]  rawRes;
    logic [RES_W-1:0]  cmpVal;
    logic [RES_W-1:0]  diffRes;
    logic [RES_W-1:0]  storeVal;
    logic              cmpTrue;
    logic              convEnd;
    logic              hit;
    logic              transfer;
    logic              lockedMode;
    logic              swStart;
    logic              hwStart;
    logic              contStart;
    logic              startNow;
    logic [CHAN_W-1:0] chanSel;
    logic [DATA_W-1:0] rdMux;

    // ************************************************************
    // Bus decode
    // ************************************************************
    assign wrCtrl1 = wrStrobe && (addr == OFF_CTRL1);
    assign wrCtrl2 = wrStrobe && (addr == OFF_CTRL2);
    assign rdHigh  = rdStrobe && (addr == OFF_RESH);
    assign rdLow   = rdStrobe && (addr == OFF_RESL);
    assign busy    = (state_reg == ACR_BUSY);

    acr_trig_sync u_acr_trig_sync (
        .mclk        (mclk),
        .rst         (rst),
        .hwTriggerIn (hwTriggerIn),
        .trigEvent   (trigEvent)
    );

    // ************************************************************
    // Software-written configuration
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqEn_reg <= 1'b0;
            cont_reg  <= 1'b0;
            chan_reg  <= CHAN_RST;
        end else if (wrCtrl1) begin
            irqEn_reg <= wrData[IRQEN_BIT];
            cont_reg  <= wrData[CONT_BIT];
            chan_reg  <= wrData[CHAN_LSB +: CHAN_W];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trig_reg  <= 1'b0;
            cmpEn_reg <= 1'b0;
            cmpGe_reg <= 1'b0;
        end else if (wrCtrl2) begin
            trig_reg  <= wrData[TRIG_BIT];
            cmpEn_reg <= wrData[CMPEN_BIT];
            cmpGe_reg <= wrData[CMPGE_BIT];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmpVal_reg <= '0;
            mode_reg   <= MODE_RST;
        end else if (wrStrobe) begin
            if (addr == OFF_CVH) begin
                cmpVal_reg[11:8] <= wrData[3:0];
            end
            if (addr == OFF_CVL) begin
                cmpVal_reg[7:0] <= wrData;
            end
            if (addr == OFF_CFG) begin
                mode_reg <= wrData[MODE_LSB +: 2];
            end
        end
    end

    // ************************************************************
    // Result formatting and compare
    // ************************************************************
    assign rawRes  = acr_mask(convResultIn, mode_reg);
    assign cmpVal  = acr_mask(cmpVal_reg, mode_reg);
    assign cmpTrue = cmpGe_reg ? (rawRes >= cmpVal)
                               : (rawRes < cmpVal);
    // Abort by a control-one write wins over a coincident completion
    assign convEnd = busy && convDoneIn && !wrCtrl1;
    assign hit     = convEnd && (!cmpEn_reg || cmpTrue);
    assign diffRes = rawRes + (~cmpVal) + 12'h001;
    assign storeVal = cmpEn_reg ? acr_mask(diffRes, mode_reg)
                                : rawRes;
    assign lockedMode = (mode_reg == MODE_12) || (mode_reg == MODE_10);
    assign transfer   = hit && !lock_reg;

    // ************************************************************
    // Start sources and sequencing
    // ************************************************************
    assign swStart = wrCtrl1 && !trig_reg
                     && (wrData[CHAN_LSB +: CHAN_W] != CHAN_OFF);
    assign hwStart = trigEvent && trig_reg && !busy && !wrCtrl1
                     && (chan_reg != CHAN_OFF);
    assign contStart = convEnd && cont_reg
                       && (chan_reg != CHAN_OFF);
    assign startNow  = swStart || hwStart || contStart;
    assign chanSel   = wrCtrl1 ? wrData[CHAN_LSB +: CHAN_W] : chan_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ACR_IDLE: begin
                if (startNow) begin
                    state_next = ACR_BUSY;
                end
            end
            ACR_BUSY: begin
                if (startNow) begin
                    state_next = ACR_BUSY;
                end else if (wrCtrl1 || convEnd) begin
                    state_next = ACR_IDLE;
                end
            end
            default: state_next = ACR_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ACR_IDLE;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg  <= (state_next == ACR_BUSY);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            convStart_reg <= 1'b0;
            convAbort_reg <= 1'b0;
        end else begin
            convStart_reg <= startNow;
            convAbort_reg <= wrCtrl1 && busy;
        end
    end

    // Channel routing latched at start, steady for the conversion
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            convChannel_reg <= CHAN_RST;
            convPinSel_reg  <= 1'b0;
            convRefHigh_reg <= 1'b0;
            convRefLow_reg  <= 1'b0;
        end else if (startNow) begin
            convChannel_reg <= chanSel;
            convPinSel_reg  <= (chanSel <= CHAN_LASTP);
            convRefHigh_reg <= (chanSel == CHAN_REFH);
            convRefLow_reg  <= (chanSel == CHAN_REFL);
        end
    end

    // ************************************************************
    // Done flag, interlock, results
    // ************************************************************
    // Set wins over a same-cycle clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else if (hit) begin
            flag_reg <= 1'b1;
        end else if (wrCtrl1 || rdLow) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lock_reg <= 1'b0;
        end else if (rdLow || !lockedMode) begin
            lock_reg <= 1'b0;
        end else if (rdHigh) begin
            lock_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resHigh_reg <= 4'h0;
            resLow_reg  <= 8'h00;
        end else if (transfer) begin
            resHigh_reg <= storeVal[11:8];
            resLow_reg  <= storeVal[7:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= flag_reg && irqEn_reg;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb begin
        rdMux = 8'h00;
        case (addr)
            OFF_CTRL1: rdMux = {flag_reg, irqEn_reg, cont_reg, chan_reg};
            OFF_CTRL2: rdMux = {busy, trig_reg, cmpEn_reg, cmpGe_reg,
                                4'h0};
            OFF_RESH:  rdMux = {4'h0, resHigh_reg};
            OFF_RESL:  rdMux = resLow_reg;
            OFF_CVH:   rdMux = {4'h0, cmpVal_reg[11:8]};
            OFF_CVL:   rdMux = cmpVal_reg[7:0];
            OFF_CFG:   rdMux = {4'h0, mode_reg, 2'h0};
            default:   rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdData_reg <= 8'h00;
        end else begin
            rdData_reg <= rdStrobe ? rdMux : 8'h00;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_flag_set;
        hit |=> flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("done flag not set on hit");

    property p_flag_miss;
        convEnd && cmpEn_reg && !cmpTrue && !flag_reg |=> !flag_reg;
    endproperty
    a_flag_miss: assert property (p_flag_miss)
        else $error("done flag set on compare miss");

    property p_flag_clr;
        (wrCtrl1 || rdLow) && !hit |=> !flag_reg;
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("done flag not cleared");

    property p_irq;
        flag_reg && irqEn_reg |=> irq_reg;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request missing");

    property p_single_idle;
        convEnd && !cont_reg |=> !busy_reg && !convStart_reg;
    endproperty
    a_single_idle: assert property (p_single_idle)
        else $error("single conversion did not power down");

    property p_cont;
        contStart |=> busy_reg && convStart_reg;
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuous restart missing");

    property p_off;
        wrCtrl1 && (wrData[CHAN_LSB +: CHAN_W] == CHAN_OFF)
            |=> !busy_reg && !convStart_reg;
    endproperty
    a_off: assert property (p_off)
        else $error("converter not switched off");

    property p_sw_start;
        swStart |=> convStart_reg && busy_reg
                    && (convChannel_reg == $past(wrData[4:0]));
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start missing");

    property p_hw_start;
        hwStart |=> convStart_reg && busy_reg;
    endproperty
    a_hw_start: assert property (p_hw_start)
        else $error("hardware start missing");

    property p_lock;
        lock_reg && !rdLow |=> $stable(resHigh_reg) && $stable(resLow_reg);
    endproperty
    a_lock: assert property (p_lock)
        else $error("result changed while locked");

    property p_mask10;
        transfer && (mode_reg == MODE_10) |=> resHigh_reg[3:2] == 2'h0;
    endproperty
    a_mask10: assert property (p_mask10)
        else $error("10-bit upper bits not zero");

    c_cont: cover property (contStart ##[1:40] contStart);
    c_lock: cover property (rdHigh && lockedMode ##[1:20] rdLow);
    c_cmp_hit: cover property (hit && cmpEn_reg);
    c_hw: cover property (hwStart ##[1:40] convEnd);

endmodule : acr_top

// *** tb_acr_top.sv ***
`timescale 1ns/1ps
module tb_acr_top
    import acr_pkg::*;
;
    // ****************************************************
    // Signals
    // ****************************************************
    logic              mclk = 1'b0;
    logic              rst  = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wrData = '0;
    logic              wrStrobe = 1'b0;
    logic              rdStrobe = 1'b0;
    logic [DATA_W-1:0] rdData_reg;
    logic              hwTriggerIn = 1'b0;
    logic              convDoneIn = 1'b0;
    logic [RES_W-1:0]  convResultIn = '0;
    logic              convStart_reg;
    logic              convAbort_reg;
    logic              busy_reg;
    logic [CHAN_W-1:0] convChannel_reg;
    logic              convPinSel_reg;
    logic              convRefHigh_reg;
    logic              convRefLow_reg;
    logic              irq_reg;
    int                errors = 0;
    int                checkCount = 0;
    int                cycles = 0;

    always #12.5 mclk = ~mclk;

    acr_top u_acr_top (
        .mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData_reg(rdData_reg), .hwTriggerIn(hwTriggerIn),
        .convDoneIn(convDoneIn), .convResultIn(convResultIn),
        .convStart_reg(convStart_reg), .convAbort_reg(convAbort_reg),
        .busy_reg(busy_reg), .convChannel_reg(convChannel_reg),
        .convPinSel_reg(convPinSel_reg),
        .convRefHigh_reg(convRefHigh_reg),
        .convRefLow_reg(convRefLow_reg), .irq_reg(irq_reg)
    );

    // ****************************************************
    // Checking and bus tasks
    // ****************************************************
    task automatic print_verdict;
        $display("errors %0d checks %0d", errors, checkCount);
        if (errors == 0 && checkCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: byte %h want %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: bit %b want %b", $time, got, exp);
        end
    endtask : chk1

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr     <= a;
        wrData   <= d;
        wrStrobe <= 1'b1;
        @(posedge mclk);
        wrStrobe <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr     <= a;
        rdStrobe <= 1'b1;
        @(posedge mclk);
        rdStrobe <= 1'b0;
        #1 chk8(rdData_reg, exp);
    endtask : rd

    // Result only sampled with the one-cycle done pulse
    task automatic done(input logic [11:0] res);
        @(posedge mclk);
        convResultIn <= res;
        convDoneIn   <= 1'b1;
        @(posedge mclk);
        convDoneIn   <= 1'b0;
        #1;
    endtask : done

    task automatic starts(input int n, input int exp);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge mclk);
            #1 if (convStart_reg === 1'b1) c++;
        end
        chk8(8'(c), 8'(exp));
    endtask : starts

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_reset;
        chk1(busy_reg, 1'b0);
        chk8({3'h0, convChannel_reg}, 8'h1F);
        rd(3'h0, 8'h1F);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h00);
        rd(3'h3, 8'h00);
        rd(3'h6, 8'h00);
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h00);
    endtask : t_reset

    task automatic t_single;
        wr(3'h6, 8'h04);
        wr(3'h0, 8'h43);
        chk1(convStart_reg, 1'b1);
        chk1(convAbort_reg, 1'b0);
        chk1(busy_reg, 1'b1);
        chk8({3'h0, convChannel_reg}, 8'h03);
        rd(3'h1, 8'h80);
        done(12'hABC);
        chk1(busy_reg, 1'b0);
        chk1(convStart_reg, 1'b0);
        @(posedge mclk);
        #1 chk1(irq_reg, 1'b1);
        rd(3'h0, 8'hC3);
        rd(3'h2, 8'h0A);
        rd(3'h3, 8'hBC);
        rd(3'h0, 8'h43);
        chk1(irq_reg, 1'b0);
        wr(3'h0, 8'h43);
        done(12'h111);
        wr(3'h0, 8'h5F);
        chk1(convStart_reg, 1'b0);
        rd(3'h0, 8'h5F);
    endtask : t_single

    task automatic t_lock;
        wr(3'h0, 8'h03);
        done(12'h123);
        rd(3'h2, 8'h01);
        wr(3'h0, 8'h03);
        done(12'h456);
        rd(3'h2, 8'h01);
        rd(3'h3, 8'h23);
        wr(3'h0, 8'h03);
        done(12'h789);
        rd(3'h2, 8'h07);
        rd(3'h3, 8'h89);
    endtask : t_lock

    task automatic t_modes;
        wr(3'h6, 8'h00);
        wr(3'h0, 8'h03);
        done(12'hABC);
        rd(3'h3, 8'hBC);
        rd(3'h2, 8'h00);
        wr(3'h0, 8'h03);
        done(12'h0DE);
        rd(3'h3, 8'hDE);
        wr(3'h6, 8'h08);
        wr(3'h0, 8'h03);
        done(12'hFFF);
        rd(3'h2, 8'h03);
        rd(3'h3, 8'hFF);
        wr(3'h6, 8'h0C);
        wr(3'h0, 8'h03);
        done(12'hFFF);
        rd(3'h2, 8'h00);
    endtask : t_modes

    task automatic t_compare;
        wr(3'h6, 8'h04);
        wr(3'h4, 8'h01);
        wr(3'h5, 8'h00);
        wr(3'h1, 8'h30);
        wr(3'h0, 8'h03);
        done(12'h0F0);
        rd(3'h0, 8'h03);
        rd(3'h3, 8'hFF);
        wr(3'h0, 8'h03);
        done(12'h180);
        rd(3'h0, 8'h83);
        rd(3'h2, 8'h00);
        rd(3'h3, 8'h80);
        wr(3'h1, 8'h20);
        wr(3'h0, 8'h03);
        done(12'h0F0);
        rd(3'h2, 8'h0F);
        rd(3'h3, 8'hF0);
        wr(3'h0, 8'h03);
        done(12'h180);
        rd(3'h0, 8'h03);
        wr(3'h1, 8'h00);
    endtask : t_compare

    task automatic t_cont;
        wr(3'h0, 8'h25);
        chk1(convStart_reg, 1'b1);
        done(12'h010);
        chk1(convStart_reg, 1'b1);
        chk1(busy_reg, 1'b1);
        done(12'h020);
        rd(3'h1, 8'h80);
        wr(3'h0, 8'h3F);
        chk1(convAbort_reg, 1'b1);
        starts(4, 0);
        chk1(busy_reg, 1'b0);
    endtask : t_cont

    task automatic t_abort;
        wr(3'h0, 8'h03);
        wr(3'h0, 8'h04);
        chk1(convAbort_reg, 1'b1);
        @(posedge mclk);
        #1 chk8({3'h0, convChannel_reg}, 8'h04);
        chk1(busy_reg, 1'b1);
        done(12'h055);
        rd(3'h3, 8'h55);
    endtask : t_abort

    task automatic t_hw;
        wr(3'h1, 8'h40);
        wr(3'h0, 8'h02);
        chk1(convStart_reg, 1'b0);
        @(posedge mclk);
        hwTriggerIn <= 1'b1;
        starts(8, 1);
        chk1(busy_reg, 1'b1);
        done(12'h033);
        starts(8, 0);
        @(posedge mclk);
        hwTriggerIn <= 1'b0;
        repeat (3) @(posedge mclk);
        hwTriggerIn <= 1'b1;
        starts(8, 1);
        done(12'h044);
        rd(3'h3, 8'h44);
        @(posedge mclk);
        hwTriggerIn <= 1'b0;
        wr(3'h1, 8'h00);
    endtask : t_hw

    task automatic t_chan;
        logic [4:0] codes [7];
        logic [2:0] sel [7];
        codes = '{5'h00, 5'h0F, 5'h10, 5'h1B, 5'h1C, 5'h1D, 5'h1E};
        sel   = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h0, 3'h2, 3'h1};
        for (int i = 0; i < 7; i++) begin
            wr(3'h0, {3'h0, codes[i]});
            chk8({3'h0, convChannel_reg}, {3'h0, codes[i]});
            chk1(convPinSel_reg, sel[i][2]);
            chk1(convRefHigh_reg, sel[i][1]);
            chk1(convRefLow_reg, sel[i][0]);
        end
        wr(3'h0, 8'h1F);
    endtask : t_chan

    // ****************************************************
    // Main sequence and hang guard
    // ****************************************************
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_single();
        t_lock();
        t_modes();
        t_compare();
        t_cont();
        t_abort();
        t_hw();
        t_chan();
        print_verdict();
    end

endmodule : tb_acr_top
